// ### rtl/mcs_pkg.sv
// Shared constants and types for the module clock and state default block
package mcs_pkg;

  // Slot index, state and PLL field widths, and slot count limits
  localparam int SLOT_IDX_W = 6;
  localparam int STATE_W = 2;
  localparam int PLL_MULT_W = 6;
  localparam int PLL_DIV_W = 5;
  localparam int MIN_SLOTS = 40;
  localparam int MAX_SLOTS = 64;

  // Module slot states as reported in the status state field
  localparam logic [1:0] ST_SOFT_RESET_DISABLED = 2'h0;
  localparam logic [1:0] ST_SYNCHRONOUS_RESET = 2'h1;
  localparam logic [1:0] ST_DISABLED = 2'h2;
  localparam logic [1:0] ST_ENABLED = 2'h3;

  // Slot groups that default to the soft-reset-disabled state
  localparam int GRP_A_LO = 2;
  localparam int GRP_A_HI = 9;
  localparam int GRP_B_LO = 11;
  localparam int GRP_B_HI = 13;
  localparam int GRP_C_LO = 15;
  localparam int GRP_C_HI = 20;
  localparam int GRP_D_LO = 23;
  localparam int GRP_D_HI = 28;

  // Slots with their own default
  localparam int SLOT_ASYNC_PORT = 14;
  localparam int SLOT_CPU = 39;

  // Interface-mode pin codes for the async memory port slot
  localparam logic [2:0] AEM_OFF = 3'h0;
  localparam logic [2:0] AEM_MODE_A = 3'h2;
  localparam logic [2:0] AEM_MODE_B = 3'h5;

  // Reset values of a PLL controller setting
  localparam logic [PLL_MULT_W-1:0] PLL_MULT_RST = 6'h01;
  localparam logic [PLL_DIV_W-1:0] PLL_DIV_RST = 5'h01;

  // One PLL controller setting: locked selects PLL mode, else bypass
  typedef struct packed {
    logic locked;
    logic [PLL_MULT_W-1:0] mult;
    logic [PLL_DIV_W-1:0] div;
  } mcs_pll_cfg_t;

  // Boot sequencing states
  typedef enum logic [0:0] {
    BOOT_SETUP,
    RUNNING
  } mcs_phase_t;

endpackage

// ### rtl/mcs_top.sv
// Reset-default clock setup and module slot state controller
//
// Behaviour
// - Reset leaves both PLL controllers in bypass on the input clock.
// - Quick boot locks the first PLL at a preset ratio on leaving reset.
// - Each slot holds one of four states that drive its clock and reset.
// - Reset: slots 2-9,11-13,15-20,23-28 soft-reset-disabled, 39 enabled.
// - Slot 14 resets soft-reset-disabled for pins 000b, else enabled.
// - The quick-boot strap sampled at reset decides the boot PLL mode.
`timescale 1ns/1ps
module mcs_top #(
  parameter int NUM_SLOTS = 40,
  parameter logic [mcs_pkg::PLL_MULT_W-1:0] BOOT_MULT = 6'h0A,
  parameter logic [mcs_pkg::PLL_DIV_W-1:0] BOOT_DIV = 5'h01
) (
  input wire logic i_mclk, // 100 MHz device input clock
  input wire logic i_srst, // Global reset, sync, active high
  input wire logic i_quick_boot, // Quick-boot strap
  input wire logic [2:0] i_async_if_mode_pins, // Interface-mode straps
  input wire logic i_pll1_wr, // Load first PLL setting
  input wire mcs_pkg::mcs_pll_cfg_t i_pll1_cfg, // New first PLL setting
  input wire logic i_pll2_wr, // Load second PLL setting
  input wire mcs_pkg::mcs_pll_cfg_t i_pll2_cfg, // New second PLL setting
  input wire logic i_slot_wr, // Slot state write strobe
  input wire logic [mcs_pkg::SLOT_IDX_W-1:0] i_slot_idx, // Target slot
  input wire logic [1:0] i_slot_state, // Requested slot state
  output logic o_boot_busy, // Writes ignored while high
  output mcs_pkg::mcs_pll_cfg_t o_pll_controller_one, // First PLL
  output mcs_pkg::mcs_pll_cfg_t o_pll_controller_two, // Second PLL
  output logic [2*NUM_SLOTS-1:0] o_slot_status_state, // Per-slot state
  output logic [NUM_SLOTS-1:0] o_slot_clk_en, // Per-slot clock on
  output logic [NUM_SLOTS-1:0] o_slot_rst_n // Per-slot reset, low
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  // Slot 39 must exist and the index port must reach every slot
  if (NUM_SLOTS < mcs_pkg::MIN_SLOTS || NUM_SLOTS > mcs_pkg::MAX_SLOTS) begin
    $error("mcs_top: NUM_SLOTS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode functions

  // True where a module sits behind the slot
  function automatic logic slot_present(input int idx);
    logic hit;
    hit = (idx >= mcs_pkg::GRP_A_LO && idx <= mcs_pkg::GRP_A_HI) ||
          (idx >= mcs_pkg::GRP_B_LO && idx <= mcs_pkg::GRP_B_HI) ||
          (idx >= mcs_pkg::GRP_C_LO && idx <= mcs_pkg::GRP_C_HI) ||
          (idx >= mcs_pkg::GRP_D_LO && idx <= mcs_pkg::GRP_D_HI) ||
          (idx == mcs_pkg::SLOT_ASYNC_PORT) ||
          (idx == mcs_pkg::SLOT_CPU);
    return hit;
  endfunction

  // Default state of a present slot for the given mode pins
  function automatic logic [1:0] slot_default(input int idx,
                                              input logic [2:0] aem);
    logic [1:0] st;
    st = mcs_pkg::ST_SOFT_RESET_DISABLED;
    if (idx == mcs_pkg::SLOT_CPU) begin
      st = mcs_pkg::ST_ENABLED;
    end else if (idx == mcs_pkg::SLOT_ASYNC_PORT) begin
      // Reserved pin codes are treated like the two valid modes
      st = (aem == mcs_pkg::AEM_OFF) ? mcs_pkg::ST_SOFT_RESET_DISABLED
                                     : mcs_pkg::ST_ENABLED;
    end
    return st;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and boot phase

  logic qb_strap_ff;
  logic [2:0] aem_strap_ff;
  mcs_pkg::mcs_phase_t phase_ff;
  mcs_pkg::mcs_phase_t nxt_phase;
  logic run_ok;

  // Straps follow the pins during reset and freeze at release
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      qb_strap_ff <= i_quick_boot;
      aem_strap_ff <= i_async_if_mode_pins;
    end
  end

  // One setup cycle after reset lets boot code act before software
  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      mcs_pkg::BOOT_SETUP: nxt_phase = mcs_pkg::RUNNING;
      mcs_pkg::RUNNING: nxt_phase = mcs_pkg::RUNNING;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      phase_ff <= mcs_pkg::BOOT_SETUP;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign run_ok = (phase_ff == mcs_pkg::RUNNING) && !i_srst;
  assign o_boot_busy = !run_ok;

  ////////////////////////////////////////////////////////////////////////////
  // PLL controllers

  mcs_pkg::mcs_pll_cfg_t pll1_ff;
  mcs_pkg::mcs_pll_cfg_t pll2_ff;
  mcs_pkg::mcs_pll_cfg_t pll_rst;
  mcs_pkg::mcs_pll_cfg_t pll_boot;
  mcs_pkg::mcs_pll_cfg_t nxt_pll1;
  mcs_pkg::mcs_pll_cfg_t nxt_pll2;
  logic boot_lock;

  assign pll_rst = '{locked: 1'b0, mult: mcs_pkg::PLL_MULT_RST,
                     div: mcs_pkg::PLL_DIV_RST};
  assign pll_boot = '{locked: 1'b1, mult: BOOT_MULT, div: BOOT_DIV};

  // Quick boot locks only the first PLL; the second stays in bypass
  assign boot_lock = (phase_ff == mcs_pkg::BOOT_SETUP) && qb_strap_ff;
  assign nxt_pll1 = boot_lock ? pll_boot :
                    (run_ok && i_pll1_wr) ? i_pll1_cfg : pll1_ff;
  assign nxt_pll2 = (run_ok && i_pll2_wr) ? i_pll2_cfg : pll2_ff;

  // Reset forces bypass on both controllers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pll1_ff <= pll_rst;
      pll2_ff <= pll_rst;
    end else begin
      pll1_ff <= nxt_pll1;
      pll2_ff <= nxt_pll2;
    end
  end

  assign o_pll_controller_one = pll1_ff;
  assign o_pll_controller_two = pll2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Module slots

  localparam int IDX_W = mcs_pkg::SLOT_IDX_W;

  // Absent slots hold no flops, so a stray write cannot wake them
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    logic [1:0] st;
    if (slot_present(g)) begin : g_live
      logic [1:0] state_ff;
      logic [1:0] nxt_state;
      logic wr_hit;
      logic [1:0] rst_state;
      assign wr_hit = run_ok && i_slot_wr &&
                      (i_slot_idx == IDX_W'(g));
      assign rst_state = slot_default(g, i_async_if_mode_pins);
      assign nxt_state = wr_hit ? i_slot_state : state_ff;
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          state_ff <= rst_state;
        end else begin
          state_ff <= nxt_state;
        end
      end
      assign st = state_ff;
    end else begin : g_absent
      assign st = mcs_pkg::ST_DISABLED;
    end
    assign o_slot_status_state[2*g +: 2] = st;
    // Clock runs in enabled and sync reset; reset held in both reset states
    assign o_slot_clk_en[g] = (st == mcs_pkg::ST_ENABLED) ||
                              (st == mcs_pkg::ST_SYNCHRONOUS_RESET);
    assign o_slot_rst_n[g] = (st == mcs_pkg::ST_ENABLED) ||
                             (st == mcs_pkg::ST_DISABLED);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  // Helpers for the slot write check: last cycle's index and state
  logic [mcs_pkg::SLOT_IDX_W-1:0] wr_idx_ff;
  logic [1:0] wr_state_ff;
  logic [1:0] wr_slot_now;
  logic wr_live;
  always_ff @(posedge i_mclk) begin
    wr_idx_ff <= i_slot_idx;
    wr_state_ff <= i_slot_state;
  end
  // Only read after a live write, so the index is always in range
  assign wr_slot_now = o_slot_status_state[2*wr_idx_ff +: 2];
  assign wr_live = run_ok && i_slot_wr && (int'(i_slot_idx) < NUM_SLOTS) &&
                   slot_present(int'(i_slot_idx));

  pll_bypass_a: assert property ($fell(i_srst) |->
    !o_pll_controller_one.locked && !o_pll_controller_two.locked)
    else $error("PLL not in bypass after reset");

  pll_two_idle_a: assert property ($fell(i_srst) |=>
    !o_pll_controller_two.locked)
    else $error("second PLL left bypass during boot");

  quick_lock_a: assert property (($fell(i_srst) && qb_strap_ff) |=>
    o_pll_controller_one.locked && o_pll_controller_one.mult == BOOT_MULT &&
    o_pll_controller_one.div == BOOT_DIV)
    else $error("quick boot did not lock first PLL");

  plain_boot_a: assert property (($fell(i_srst) && !qb_strap_ff) |=>
    !o_pll_controller_one.locked ##1 (!o_pll_controller_one.locked ||
    $past(i_pll1_wr)))
    else $error("PLL locked without quick boot");

  slot_write_a: assert property (wr_live |=>
    wr_slot_now == wr_state_ff)
    else $error("slot write not applied");

  busy_block_a: assert property (o_boot_busy |=>
    $stable(o_slot_status_state))
    else $error("slot changed during boot setup");

  cpu_default_a: assert property ($fell(i_srst) |->
    o_slot_status_state[2*mcs_pkg::SLOT_CPU +: 2] == mcs_pkg::ST_ENABLED &&
    o_slot_clk_en[mcs_pkg::SLOT_CPU] &&
    o_slot_rst_n[mcs_pkg::SLOT_CPU])
    else $error("cpu slot not enabled after reset");

  group_default_a: assert property ($fell(i_srst) |->
    o_slot_status_state[2*mcs_pkg::GRP_A_LO +: 2] ==
      mcs_pkg::ST_SOFT_RESET_DISABLED &&
    o_slot_status_state[2*mcs_pkg::GRP_D_HI +: 2] ==
      mcs_pkg::ST_SOFT_RESET_DISABLED &&
    !o_slot_clk_en[mcs_pkg::GRP_C_LO])
    else $error("peripheral slot default wrong");

  async_default_a: assert property ($fell(i_srst) |->
    o_slot_status_state[2*mcs_pkg::SLOT_ASYNC_PORT +: 2] ==
      ((aem_strap_ff == mcs_pkg::AEM_OFF) ? mcs_pkg::ST_SOFT_RESET_DISABLED
                                          : mcs_pkg::ST_ENABLED))
    else $error("async port slot default wrong");

  absent_slot_a: assert property (
    o_slot_status_state[21*2 +: 2] == mcs_pkg::ST_DISABLED &&
    o_slot_status_state[10*2 +: 2] == mcs_pkg::ST_DISABLED &&
    !o_slot_clk_en[10] && o_slot_rst_n[10])
    else $error("absent slot not disabled");

  quick_boot_c: cover property ($fell(i_srst) && qb_strap_ff);
  async_mode_c: cover property ($fell(i_srst) &&
    aem_strap_ff == mcs_pkg::AEM_MODE_A);
  slot_sync_c: cover property (wr_live &&
    i_slot_state == mcs_pkg::ST_SYNCHRONOUS_RESET);
  pll_reprog_c: cover property (run_ok && i_pll1_wr && i_pll1_cfg.locked);

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the clock and slot state default block
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module tb_top;
  localparam logic [5:0] B_MULT = 6'h0C;
  localparam logic [4:0] B_DIV = 5'h02;
  localparam mcs_pkg::mcs_pll_cfg_t BYP = {1'b0, 6'h01, 5'h01};
  localparam mcs_pkg::mcs_pll_cfg_t BOOT = {1'b1, B_MULT, B_DIV};
  logic i_mclk, i_srst, i_quick_boot, i_pll1_wr, i_pll2_wr, i_slot_wr;
  logic [2:0] i_async_if_mode_pins;
  mcs_pkg::mcs_pll_cfg_t i_pll1_cfg, i_pll2_cfg, o_pll1, o_pll2;
  logic [5:0] i_slot_idx;
  logic [1:0] i_slot_state;
  logic o_boot_busy;
  logic [79:0] o_state;
  logic [39:0] o_clk_en, o_rst_n;
  int bad_count = 0;
  int samples_checked = 0;
  mcs_top #(.NUM_SLOTS(40), .BOOT_MULT(B_MULT), .BOOT_DIV(B_DIV))
    mcs_top_inst (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_quick_boot(i_quick_boot), .i_async_if_mode_pins(i_async_if_mode_pins),
    .i_pll1_wr(i_pll1_wr), .i_pll1_cfg(i_pll1_cfg), .i_pll2_wr(i_pll2_wr),
    .i_pll2_cfg(i_pll2_cfg), .i_slot_wr(i_slot_wr), .i_slot_idx(i_slot_idx),
    .i_slot_state(i_slot_state), .o_boot_busy(o_boot_busy),
    .o_pll_controller_one(o_pll1), .o_pll_controller_two(o_pll2),
    .o_slot_status_state(o_state), .o_slot_clk_en(o_clk_en),
    .o_slot_rst_n(o_rst_n));
  ////////////////////////////////////////////////////////////////////////
  // Expected reset default of one slot, absent slots read disabled
  function automatic logic [1:0] exp_state(int n, logic [2:0] pins);
    if ((n >= 2 && n <= 9) || (n >= 11 && n <= 13) ||
        (n >= 15 && n <= 20) || (n >= 23 && n <= 28))
      return 2'h0;
    if (n == 14)
      return (pins == 3'h0) ? 2'h0 : 2'h3;
    if (n == 39)
      return 2'h3;
    return 2'h2;
  endfunction
  // Status, clock gate and reset of one slot against a state
  task automatic chk_slot(input int n, input logic [1:0] st);
    `CHK(o_state[2*n +: 2], st)
    `CHK(o_clk_en[n], (st == 2'h3 || st == 2'h1))
    `CHK(o_rst_n[n], (st == 2'h3 || st == 2'h2))
  endtask
  // Writes made in the last busy cycle must be dropped
  task automatic do_reset(input logic qb, input logic [2:0] pins);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    i_quick_boot <= qb;
    i_async_if_mode_pins <= pins;
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    i_slot_wr <= 1'b1;
    i_slot_idx <= 6'h05;
    i_slot_state <= 2'h3;
    i_pll2_wr <= 1'b1;
    i_pll2_cfg <= BOOT;
    #1;
    `CHK(o_boot_busy, 1'b1)
    `CHK(o_pll1, BYP)
    @(posedge i_mclk);
    i_slot_wr <= 1'b0;
    i_pll2_wr <= 1'b0;
    #1;
    `CHK(o_boot_busy, 1'b0)
    `CHK(o_pll1, qb ? BOOT : BYP)
    `CHK(o_pll2, BYP)
    for (int n = 0; n < 40; n++) begin
      chk_slot(n, exp_state(n, pins));
    end
  endtask
  task automatic slot_write(input int n, input logic [1:0] st);
    @(posedge i_mclk);
    i_slot_wr <= 1'b1;
    i_slot_idx <= n[5:0];
    i_slot_state <= st;
    @(posedge i_mclk);
    i_slot_wr <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Four strap combinations: pins 000b with quick boot off and on, plus the mode A and mode B codes
  task automatic t_boot_defaults();
    do_reset(1'b0, 3'h0);
    do_reset(1'b1, 3'h2);
    do_reset(1'b0, 3'h5);
    do_reset(1'b1, 3'h0);
    $display("test boot_defaults done");
  endtask
  // All four states on slot 14, sync reset on slot 39, then writes to absent slots
  task automatic t_slot_states();
    for (int s = 0; s < 4; s++) begin
      slot_write(14, s[1:0]);
      chk_slot(14, s[1:0]);
    end
    slot_write(39, 2'h1);
    chk_slot(39, 2'h1);
    slot_write(10, 2'h3);
    chk_slot(10, 2'h2);
    slot_write(0, 2'h3);
    chk_slot(0, 2'h2);
    slot_write(38, 2'h0);
    chk_slot(38, 2'h2);
    $display("test slot_states done");
  endtask
  // Software reprograms both controllers after a quick boot
  task automatic t_pll_prog();
    do_reset(1'b1, 3'h2);
    @(posedge i_mclk);
    i_pll1_wr <= 1'b1;
    i_pll1_cfg <= {1'b1, 6'h14, 5'h03};
    i_pll2_wr <= 1'b1;
    i_pll2_cfg <= {1'b1, 6'h08, 5'h01};
    @(posedge i_mclk);
    i_pll1_wr <= 1'b0;
    i_pll2_wr <= 1'b0;
    #1;
    `CHK(o_pll1, {1'b1, 6'h14, 5'h03})
    `CHK(o_pll2, {1'b1, 6'h08, 5'h01})
    $display("test pll_prog done");
  endtask
  task automatic summarize();
    $display("Compares %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Free running 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Main sequence, straps and strobes quiet at time zero
  initial begin
    i_srst = 1'b1;
    i_quick_boot = 1'b0;
    i_async_if_mode_pins = 3'h0;
    i_pll1_wr = 1'b0;
    i_pll2_wr = 1'b0;
    i_slot_wr = 1'b0;
    i_pll1_cfg = BYP;
    i_pll2_cfg = BYP;
    i_slot_idx = 6'h00;
    i_slot_state = 2'h0;
    t_boot_defaults();
    t_slot_states();
    t_pll_prog();
    summarize();
  end
  // Whole run is about 110 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge i_mclk);
    bad_count++;
    summarize();
  end
endmodule
